/* oss_startup_ctrl.sv */
`timescale 1ns/1ps
module oss_startup_ctrl import oss_pkg::*; #(
    parameter logic [31:0] DEV_BASE = 32'h0008_0000,
    parameter logic [31:0] SUB_DRV_VAL = 32'h0000_0000,
    parameter logic [31:0] PLL_CFG_VAL = 32'h0000_0000,
    parameter int unsigned MAIN_WAIT_CYC = int'(MAIN_SW_CYC),
    parameter int unsigned PLL_WAIT_CYC = int'(PLL_SW_CYC),
    parameter int unsigned SUB_WAIT_CYC = int'(SUB_SW_CYC),
    parameter int unsigned FAST_WAIT_CYC = int'(FAST_SW_CYC)
) (
    input wire logic hclk,
    input wire logic hresetn,
    // Slave port for the own registers
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Master port toward the device registers
    output logic [31:0] m_haddr,
    output logic [1:0] m_htrans,
    output logic m_hwrite,
    output logic [2:0] m_hsize,
    output logic [31:0] m_hwdata,
    input wire logic m_hready
);
    // All controller state
    typedef struct packed {
        oss_state_t st;
        logic [4:0] step;
        logic [3:0] cfg;
        logic [4:0] main_code;
        logic [4:0] pll_code;
        logic [4:0] sub_code;
        logic [31:0] divs;
        logic done;
        logic main_ok;
        logic pwr_ok;
        logic s_wr;
        logic [3:0] s_off;
        logic [31:0] rdata;
        logic [31:0] maddr;
        logic [1:0] mtrans;
        logic [31:0] mwdata;
        logic [31:0] wcnt;
    } oss_ctl_t;
    oss_ctl_t q_r; // Registered state
    oss_ctl_t q_nxt; // Next state
    oss_step_t cur; // Table entry for current step
    logic tmr_load; // Start a software wait
    logic [31:0] tmr_val; // Length of that wait
    logic tmr_busy; // Software wait running
    logic busy; // Sequence in progress
    logic last; // Current step is the final one

    // Bring-up table; order of steps keeps the sequence
    function automatic oss_step_t step_info(input logic [4:0] idx, input logic [3:0] cfg,
                                            input logic [4:0] mc, input logic [4:0] pc,
                                            input logic [4:0] sc, input logic [31:0] dv);
        oss_step_t s;
        s = '{skip: 1'b0, wsel: OSS_W_NONE, addr: DEV_SUB_CTL, data: CTL_OFF};
        case (idx)
            5'h00: s.data = CTL_OFF;
            5'h01: begin
                s.skip = !cfg[CFG_USE_SUB];
                s.addr = DEV_SUB_DRV;
                s.data = SUB_DRV_VAL;
            end
            5'h02: begin
                s.skip = !cfg[CFG_USE_SUB];
                s.addr = DEV_SUB_WAIT;
                s.data = {27'h0, sc};
            end
            5'h03: begin
                s.skip = !cfg[CFG_USE_SUB];
                s.data = CTL_RUN;
                s.wsel = OSS_W_SUB;
            end
            5'h04: begin
                s.addr = DEV_MAIN_DRV;
                s.data = MAIN_DRV_VAL;
            end
            5'h05: begin
                s.addr = DEV_MAIN_WAIT;
                s.data = {27'h0, mc};
            end
            5'h06: begin
                s.addr = DEV_MAIN_CTL;
                s.data = CTL_RUN;
                s.wsel = OSS_W_MAIN;
            end
            5'h07: begin
                s.skip = !cfg[CFG_USE_PLL];
                s.addr = DEV_PLL_CFG;
                s.data = PLL_CFG_VAL;
            end
            5'h08: begin
                s.skip = !cfg[CFG_USE_PLL];
                s.addr = DEV_PLL_WAIT;
                s.data = {27'h0, pc};
            end
            5'h09: begin
                s.skip = !cfg[CFG_USE_PLL];
                s.addr = DEV_PLL_CTL;
                s.data = CTL_RUN;
                s.wsel = OSS_W_PLL;
            end
            5'h0A: begin
                s.skip = cfg[CFG_USE_PLL];
                s.addr = DEV_PLL_CTL;
                s.data = CTL_OFF;
            end
            5'h0B: begin
                s.skip = !cfg[CFG_USE_FAST];
                s.addr = DEV_FAST_CFG;
                s.data = cfg[CFG_FAST50] ? FAST_FREQ_50 : FAST_FREQ_OTHER;
            end
            5'h0C: begin
                s.skip = !cfg[CFG_USE_FAST];
                s.addr = DEV_FAST_WAIT;
                s.data = cfg[CFG_FAST50] ? FAST_WAIT_50 : FAST_WAIT_OTHER;
            end
            5'h0D: begin
                s.skip = !cfg[CFG_USE_FAST];
                s.addr = DEV_FAST_CTL;
                s.data = CTL_RUN;
                s.wsel = OSS_W_FAST;
            end
            5'h0E: begin
                s.skip = cfg[CFG_USE_FAST];
                s.addr = DEV_FAST_CTL;
                s.data = CTL_OFF;
            end
            5'h0F: begin
                s.addr = DEV_PWR_MODE;
                s.data = PWR_HIGH_SPEED;
            end
            5'h10: begin
                s.addr = DEV_DIV;
                s.data = dv;
            end
            5'h11: begin
                s.addr = DEV_CLK_SEL;
                s.data = cfg[CFG_USE_PLL] ? CLKSEL_PLL : CLKSEL_MAIN;
            end
            default: s.skip = 1'b1;
        endcase
        return s;
    endfunction

    assign cur = step_info(q_r.step, q_r.cfg, q_r.main_code, q_r.pll_code, q_r.sub_code, q_r.divs);
    assign busy = (q_r.st != OSS_IDLE);
    assign last = (q_r.step == ST_CLK_SEL);

    // Length of the software wait after an enable
    always_comb begin
        case (cur.wsel)
            OSS_W_SUB: tmr_val = SUB_WAIT_CYC;
            OSS_W_MAIN: tmr_val = MAIN_WAIT_CYC;
            OSS_W_PLL: tmr_val = PLL_WAIT_CYC;
            OSS_W_FAST: tmr_val = FAST_WAIT_CYC;
            default: tmr_val = 32'h0000_0001;
        endcase
    end

    assign tmr_load = (q_r.st == OSS_DATA) && m_hready && (cur.wsel != OSS_W_NONE);

    // Register slave, sequencer and master in one next-state block
    always_comb begin
        q_nxt = q_r;
        // Slave address phase: capture and prepare read data
        q_nxt.s_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            q_nxt.s_wr = hwrite;
            q_nxt.s_off = haddr[3:0];
            case (haddr[3:0])
                REG_CTRL: q_nxt.rdata = {27'h0, q_r.cfg, 1'b0};
                REG_CODES: q_nxt.rdata = {11'h0, q_r.sub_code, 3'h0, q_r.pll_code, 3'h0, q_r.main_code};
                REG_DIVS: q_nxt.rdata = q_r.divs;
                REG_STAT: q_nxt.rdata = {19'h0, q_r.step, 5'h0, q_r.main_ok, q_r.done, busy};
                default: q_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // Slave data phase: writes refused while busy
        if (q_r.s_wr && !busy) begin
            case (q_r.s_off)
                REG_CTRL: begin
                    q_nxt.cfg = hwdata[4:1];
                    if (hwdata[0]) begin
                        q_nxt.st = OSS_PICK;
                        q_nxt.step = ST_SUB_INIT;
                        q_nxt.done = 1'b0;
                        q_nxt.main_ok = 1'b0;
                        q_nxt.pwr_ok = 1'b0;
                    end
                end
                REG_CODES: begin
                    q_nxt.main_code = hwdata[MAIN_CODE_LSB +: 5];
                    q_nxt.pll_code = hwdata[PLL_CODE_LSB +: 5];
                    q_nxt.sub_code = hwdata[SUB_CODE_LSB +: 5];
                end
                REG_DIVS: q_nxt.divs = hwdata;
                default: q_nxt.divs = q_r.divs;
            endcase
        end
        // Cycles spent so far in the current software wait
        q_nxt.wcnt = (q_r.st == OSS_WAIT) ? q_r.wcnt + 32'h0000_0001 : 32'h0000_0000;
        // Sequencer and bus master
        case (q_r.st)
            OSS_IDLE: q_nxt.mtrans = HTRANS_IDLE;
            OSS_PICK: begin
                if (cur.skip) begin
                    q_nxt.step = q_r.step + 5'h01;
                end else begin
                    q_nxt.maddr = DEV_BASE + {24'h0, cur.addr};
                    q_nxt.mtrans = HTRANS_NONSEQ;
                    q_nxt.st = OSS_ADDR;
                end
            end
            OSS_ADDR: begin
                if (m_hready) begin
                    q_nxt.mtrans = HTRANS_IDLE;
                    q_nxt.mwdata = cur.data;
                    q_nxt.st = OSS_DATA;
                end
            end
            OSS_DATA: begin
                if (m_hready) begin
                    if (q_r.step == ST_PWR) begin
                        q_nxt.pwr_ok = 1'b1;
                    end
                    if (cur.wsel != OSS_W_NONE) begin
                        q_nxt.st = OSS_WAIT;
                    end else if (last) begin
                        q_nxt.st = OSS_IDLE;
                        q_nxt.done = 1'b1;
                    end else begin
                        q_nxt.step = q_r.step + 5'h01;
                        q_nxt.st = OSS_PICK;
                    end
                end
            end
            OSS_WAIT: begin
                if (!tmr_busy) begin
                    if (q_r.step == ST_MAIN_RUN) begin
                        q_nxt.main_ok = 1'b1;
                    end
                    q_nxt.step = q_r.step + 5'h01;
                    q_nxt.st = OSS_PICK;
                end
            end
            default: q_nxt.st = OSS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= '{st: OSS_IDLE, step: 5'h00, cfg: CFG_RST, main_code: MAIN_CODE_RST,
                     pll_code: PLL_CODE_RST, sub_code: SUB_CODE_RST, divs: DIVS_RST,
                     done: 1'b0, main_ok: 1'b0, pwr_ok: 1'b0, s_wr: 1'b0, s_off: 4'h0,
                     rdata: 32'h0000_0000, maddr: 32'h0000_0000, mtrans: HTRANS_IDLE,
                     mwdata: 32'h0000_0000, wcnt: 32'h0000_0000};
        end else begin
            q_r <= q_nxt;
        end
    end

    oss_wait_timer #(
        .W(32)
    ) u_wait (
        .hclk(hclk),
        .hresetn(hresetn),
        .load(tmr_load),
        .load_val(tmr_val),
        .busy(tmr_busy)
    );

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q_r.rdata;
    assign m_haddr = q_r.maddr;
    assign m_htrans = q_r.mtrans;
    assign m_hwrite = 1'b1;
    assign m_hsize = HSIZE_WORD;
    assign m_hwdata = q_r.mwdata;

    // Clock switch only as the final write
    a_clk_sel_last: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_DATA && m_hready && q_r.step == ST_CLK_SEL) |=> (q_r.st == OSS_IDLE && q_r.done))
        else $error("clock switch not final");

    // First device write initialises the sub-clock
    a_sub_first: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_PICK && q_r.step == ST_SUB_INIT) |=> (m_htrans == HTRANS_NONSEQ && m_haddr == DEV_BASE))
        else $error("sub-clock not initialised first");

    // No device transfer while a software wait runs
    a_wait_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        tmr_busy |-> (m_htrans == HTRANS_IDLE))
        else $error("transfer during stabilisation wait");

    // PLL enable only after the main wait is over
    a_pll_after_main: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_ADDR && q_r.step == ST_PLL_RUN) |-> q_r.main_ok)
        else $error("PLL enabled before main wait");

    // PLL software wait runs its full count before the next step
    a_pll_wait_len: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_WAIT && !tmr_busy && q_r.step == ST_PLL_RUN) |-> (q_r.wcnt >= PLL_WAIT_CYC))
        else $error("PLL software wait too short");

    // Main software wait runs its full count before the PLL steps
    a_main_wait_len: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_WAIT && !tmr_busy && q_r.step == ST_MAIN_RUN) |-> (q_r.wcnt >= MAIN_WAIT_CYC))
        else $error("main software wait too short");

    // Power mode written before dividers
    a_pwr_before_div: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_ADDR && q_r.step == ST_DIV) |-> q_r.pwr_ok)
        else $error("dividers before power mode");

    // Unused PLL gets a power-off write, never an enable
    a_pll_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_DATA && m_haddr == DEV_BASE + {24'h0, DEV_PLL_CTL}) |->
        (m_hwdata == (q_r.cfg[CFG_USE_PLL] ? CTL_RUN : CTL_OFF)))
        else $error("wrong PLL control write");

    // Fast oscillator wait code by frequency
    a_fast_code: assert property (@(posedge hclk) disable iff (!hresetn)
        (q_r.st == OSS_DATA && q_r.step == ST_FAST_WAIT) |->
        (m_hwdata == (q_r.cfg[CFG_FAST50] ? 32'h0000_0003 : 32'h0000_0002)))
        else $error("fast oscillator wait code wrong");

    // Address phase held until the slave is ready
    a_addr_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (m_htrans == HTRANS_NONSEQ && !m_hready) |=> (m_htrans == HTRANS_NONSEQ && $stable(m_haddr)))
        else $error("address phase dropped");
endmodule

/* oss_pkg.sv */
package oss_pkg;
    // Rates and software wait times
    localparam longint CLK_HZ = 40_000_000;
    localparam longint MAIN_SW_WAIT_NS = 13_107_200;
    localparam longint PLL_SW_WAIT_NS = 1_500_000;
    localparam longint SUB_SW_WAIT_MS = 4_000;
    localparam longint FAST_SW_WAIT_NS = 350_000;
    // Least times round up to whole cycles
    localparam longint MAIN_SW_CYC = (MAIN_SW_WAIT_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam longint PLL_SW_CYC = (PLL_SW_WAIT_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    localparam longint SUB_SW_CYC = (SUB_SW_WAIT_MS * CLK_HZ + 999) / 1_000;
    localparam longint FAST_SW_CYC = (FAST_SW_WAIT_NS * CLK_HZ + 999_999_999) / 1_000_000_000;
    // Own register word offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CODES = 4'h4;
    localparam logic [3:0] REG_DIVS = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // Own register reset values
    localparam logic [3:0] CFG_RST = 4'hA;
    localparam logic [4:0] MAIN_CODE_RST = 5'h0D;
    localparam logic [4:0] PLL_CODE_RST = 5'h09;
    localparam logic [4:0] SUB_CODE_RST = 5'h00;
    localparam logic [31:0] DIVS_RST = 32'h0222_2211;
    // Config bit positions
    localparam int CFG_USE_SUB = 0;
    localparam int CFG_USE_PLL = 1;
    localparam int CFG_USE_FAST = 2;
    localparam int CFG_FAST50 = 3;
    // Code field positions in the codes register
    localparam int MAIN_CODE_LSB = 0;
    localparam int PLL_CODE_LSB = 8;
    localparam int SUB_CODE_LSB = 16;
    // Device register offsets from the device base
    localparam logic [7:0] DEV_SUB_CTL = 8'h00;
    localparam logic [7:0] DEV_SUB_DRV = 8'h04;
    localparam logic [7:0] DEV_SUB_WAIT = 8'h08;
    localparam logic [7:0] DEV_MAIN_DRV = 8'h0C;
    localparam logic [7:0] DEV_MAIN_WAIT = 8'h10;
    localparam logic [7:0] DEV_MAIN_CTL = 8'h14;
    localparam logic [7:0] DEV_PLL_CFG = 8'h18;
    localparam logic [7:0] DEV_PLL_WAIT = 8'h1C;
    localparam logic [7:0] DEV_PLL_CTL = 8'h20;
    localparam logic [7:0] DEV_FAST_CFG = 8'h24;
    localparam logic [7:0] DEV_FAST_WAIT = 8'h28;
    localparam logic [7:0] DEV_FAST_CTL = 8'h2C;
    localparam logic [7:0] DEV_PWR_MODE = 8'h30;
    localparam logic [7:0] DEV_DIV = 8'h34;
    localparam logic [7:0] DEV_CLK_SEL = 8'h38;
    // Device register values
    localparam logic [31:0] CTL_RUN = 32'h0000_0001;
    localparam logic [31:0] CTL_OFF = 32'h0000_0000;
    localparam logic [31:0] MAIN_DRV_VAL = 32'h0000_0030;
    localparam logic [31:0] PWR_HIGH_SPEED = 32'h0000_0000;
    localparam logic [31:0] CLKSEL_PLL = 32'h0000_0004;
    localparam logic [31:0] CLKSEL_MAIN = 32'h0000_0002;
    localparam logic [31:0] FAST_FREQ_50 = 32'h0000_0003;
    localparam logic [31:0] FAST_FREQ_OTHER = 32'h0000_0000;
    localparam logic [31:0] FAST_WAIT_50 = 32'h0000_0003;
    localparam logic [31:0] FAST_WAIT_OTHER = 32'h0000_0002;
    // Sequence step numbers
    localparam logic [4:0] ST_SUB_INIT = 5'h00;
    localparam logic [4:0] ST_MAIN_RUN = 5'h06;
    localparam logic [4:0] ST_PLL_RUN = 5'h09;
    localparam logic [4:0] ST_FAST_WAIT = 5'h0C;
    localparam logic [4:0] ST_PWR = 5'h0F;
    localparam logic [4:0] ST_DIV = 5'h10;
    localparam logic [4:0] ST_CLK_SEL = 5'h11;
    // Which software wait follows a step
    typedef enum logic [2:0] {
        OSS_W_NONE = 3'h0,
        OSS_W_SUB = 3'h1,
        OSS_W_MAIN = 3'h2,
        OSS_W_PLL = 3'h3,
        OSS_W_FAST = 3'h4
    } oss_wsel_t;
    // Sequencer states
    typedef enum logic [4:0] {
        OSS_IDLE = 5'b00001,
        OSS_PICK = 5'b00010,
        OSS_ADDR = 5'b00100,
        OSS_DATA = 5'b01000,
        OSS_WAIT = 5'b10000
    } oss_state_t;
    // One step of the bring-up table
    typedef struct packed {
        logic skip;
        oss_wsel_t wsel;
        logic [7:0] addr;
        logic [31:0] data;
    } oss_step_t;
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* oss_wait_timer.sv */
`timescale 1ns/1ps
// Down counter for one software stabilisation wait
module oss_wait_timer import oss_pkg::*; #(
    parameter int W = 32
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic busy
);
    // All timer state
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
    } oss_tmr_t;
    oss_tmr_t q_r; // Registered state
    oss_tmr_t q_nxt; // Next state

    // Load, then count to zero
    always_comb begin
        q_nxt = q_r;
        if (load) begin
            q_nxt.cnt = load_val;
            q_nxt.busy = 1'b1;
        end else if (q_r.busy) begin
            if (q_r.cnt <= W'(1)) begin
                q_nxt.cnt = '0;
                q_nxt.busy = 1'b0;
            end else begin
                q_nxt.cnt = q_r.cnt - W'(1);
            end
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign busy = q_r.busy;
endmodule

/* oss_dev_model.sv */
`timescale 1ns/1ps
// Behavioural device register block on the controller's master port
module oss_dev_model import oss_pkg::*; #(
    parameter logic [31:0] BASE = 32'h0008_0000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic [31:0] hwdata,
    input wire logic slow,
    output logic hready
);
    logic [7:0] off_r; // Offset taken in the address phase
    logic pend_r; // Data phase outstanding
    logic [31:0] regs [0:15]; // Device register words
    int cyc; // Cycle stamp
    int hold [0:1]; // Withhold counts for main and PLL output
    logic main_ok; // Main clock offered to the tree
    logic pll_ok; // PLL clock offered to the tree
    logic [7:0] log_off [$]; // Written offsets in order
    logic [31:0] log_dat [$]; // Written data in order
    int log_cyc [$]; // Cycle of each write
    // Bus side, write log and wait counters
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hready <= 1'b1;
            pend_r <= 1'b0;
            cyc <= 0;
            hold <= '{0, 0};
        end else begin
            cyc <= cyc + 1;
            // Slow mode stretches both phases
            hready <= slow ? ~hready : 1'b1;
            if (hold[0] > 0) hold[0] <= hold[0] - 1;
            if (hold[1] > 0) hold[1] <= hold[1] - 1;
            if (pend_r && hready) begin
                regs[off_r[5:2]] <= hwdata;
                log_off.push_back(off_r);
                log_dat.push_back(hwdata);
                log_cyc.push_back(cyc);
                // Scaled wait from the programmed code
                if (off_r == DEV_MAIN_CTL && hwdata == CTL_RUN) hold[0] <= 1 << regs[4][4:0];
                if (off_r == DEV_PLL_CTL && hwdata == CTL_RUN) hold[1] <= 1 << regs[7][4:0];
            end
            if (hready) pend_r <= htrans[1];
            if (htrans[1] && hready) off_r <= haddr[7:0] - BASE[7:0];
        end
    end
    // Clock reaches the tree only once its count has run out
    assign main_ok = (regs[5] === CTL_RUN) && (hold[0] == 0);
    assign pll_ok = (regs[8] === CTL_RUN) && (hold[1] == 0);
endmodule

/* test_oss_startup_ctrl.sv */
`timescale 1ns/1ps
// Bench: own registers over the slave port, device writes checked in the model log
module test_oss_startup_ctrl;
    import oss_pkg::*;
    localparam int MW = 300; // Shortened software waits
    localparam int PW = 200;
    localparam int SW = 100;
    localparam int FW = 100;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic slow = 1'b0;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic [2:0] hsize = HSIZE_WORD;
    logic hreadyout, hresp, m_hwrite, m_hready;
    logic [31:0] hrdata, m_haddr, m_hwdata;
    logic [1:0] m_htrans;
    logic [2:0] m_hsize;
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [31:0] rd; // Last read data
    logic [7:0] e_off [$]; // Expected device writes
    logic [31:0] e_dat [$];
    // Clock
    always #12.5 hclk = ~hclk;
    oss_startup_ctrl #(.MAIN_WAIT_CYC(MW), .PLL_WAIT_CYC(PW), .SUB_WAIT_CYC(SW), .FAST_WAIT_CYC(FW)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .m_haddr(m_haddr), .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize),
        .m_hwdata(m_hwdata), .m_hready(m_hready));
    oss_dev_model dev (.hclk(hclk), .hresetn(hresetn), .haddr(m_haddr), .htrans(m_htrans),
        .hwdata(m_hwdata), .slow(slow), .hready(m_hready));
    // Verdict and end of run
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Compare one word
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bounded wait for hready at a rising edge
    task rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask
    // One single word transfer; read data lands in rd
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    // Queue one expected device write
    task ex(input logic [7:0] o, input logic [31:0] d);
        e_off.push_back(o);
        e_dat.push_back(d);
    endtask
    // Full bring-up with one configuration, then check the device log
    task run(input logic [3:0] cfg, input logic [31:0] codes, input logic [31:0] divs);
        int i, g, w;
        e_off.delete();
        e_dat.delete();
        dev.log_off.delete();
        dev.log_dat.delete();
        dev.log_cyc.delete();
        ex(DEV_SUB_CTL, CTL_OFF);
        if (cfg[CFG_USE_SUB]) begin
            ex(DEV_SUB_DRV, 32'h0);
            ex(DEV_SUB_WAIT, {27'h0, codes[20:16]});
            ex(DEV_SUB_CTL, CTL_RUN);
        end
        ex(DEV_MAIN_DRV, MAIN_DRV_VAL);
        ex(DEV_MAIN_WAIT, {27'h0, codes[4:0]});
        ex(DEV_MAIN_CTL, CTL_RUN);
        if (cfg[CFG_USE_PLL]) begin
            ex(DEV_PLL_CFG, 32'h0);
            ex(DEV_PLL_WAIT, {27'h0, codes[12:8]});
            ex(DEV_PLL_CTL, CTL_RUN);
        end else ex(DEV_PLL_CTL, CTL_OFF);
        if (cfg[CFG_USE_FAST]) begin
            ex(DEV_FAST_CFG, cfg[CFG_FAST50] ? FAST_FREQ_50 : FAST_FREQ_OTHER);
            ex(DEV_FAST_WAIT, cfg[CFG_FAST50] ? FAST_WAIT_50 : FAST_WAIT_OTHER);
            ex(DEV_FAST_CTL, CTL_RUN);
        end else ex(DEV_FAST_CTL, CTL_OFF);
        ex(DEV_PWR_MODE, PWR_HIGH_SPEED);
        ex(DEV_DIV, divs);
        ex(DEV_CLK_SEL, cfg[CFG_USE_PLL] ? CLKSEL_PLL : CLKSEL_MAIN);
        xfer(1'b1, REG_CODES, codes);
        xfer(1'b1, REG_DIVS, divs);
        xfer(1'b1, REG_CTRL, {27'h0, cfg, 1'b1});
        xfer(1'b1, REG_CODES, 32'h0);
        xfer(1'b0, REG_CODES, 32'h0);
        chk("codes while busy", codes, rd);
        i = 0;
        do begin
            xfer(1'b0, REG_STAT, 32'h0);
            i++;
        end while (rd[1] !== 1'b1 && i < 900);
        if (rd[1] !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
        chk("status", 32'h6, rd & 32'h7);
        chk("slave response", 32'h0, {31'h0, hresp});
        chk("master write", 32'h1, {31'h0, m_hwrite});
        chk("master size", {29'h0, HSIZE_WORD}, {29'h0, m_hsize});
        chk("write count", e_off.size(), dev.log_off.size());
        for (i = 0; i < e_off.size() && i < dev.log_off.size(); i++) begin
            chk("device offset", {24'h0, e_off[i]}, {24'h0, dev.log_off[i]});
            chk("device data", e_dat[i], dev.log_dat[i]);
            w = (e_off[i] == DEV_SUB_CTL) ? SW : (e_off[i] == DEV_MAIN_CTL) ? MW :
                (e_off[i] == DEV_PLL_CTL) ? PW : FW;
            if (e_dat[i] == CTL_RUN && i + 1 < dev.log_cyc.size()) begin
                g = dev.log_cyc[i + 1] - dev.log_cyc[i];
                chk("software wait", 32'h1, {31'h0, g > w});
            end
        end
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, REG_CTRL, 32'h0);
        chk("ctrl reset", {27'h0, CFG_RST, 1'b0}, rd);
        xfer(1'b0, REG_CODES, 32'h0);
        chk("codes reset", 32'h0000_090D, rd);
        xfer(1'b0, REG_DIVS, 32'h0);
        chk("divs reset", DIVS_RST, rd);
        xfer(1'b0, REG_STAT, 32'h0);
        chk("stat reset", 32'h0, rd & 32'h3);
        run(CFG_RST, 32'h0000_090D, DIVS_RST);
        slow <= 1'b1;
        run(4'h5, 32'h0005_0A0E, 32'h0244_4411);
        run(4'hC, 32'h0003_0B0C, DIVS_RST);
        summarize();
    end
endmodule
